// ### shared/ccr_pkg.sv
// Package for channel one configuration registers: offsets, fields, resets
package ccr_pkg;
  localparam logic [7:0] ADDR_INPUT_SETUP = 8'h3c;
  localparam logic [7:0] ADDR_ANALOG_GAIN = 8'h3d;
  localparam logic [7:0] ADDR_DIGITAL_VOLUME = 8'h3e;
  localparam logic [7:0] ADDR_GAIN_TRIM = 8'h3f;

  localparam logic [7:0] RST_INPUT_SETUP = 8'h00;
  localparam logic [7:0] RST_ANALOG_GAIN = 8'h00;
  localparam logic [7:0] RST_DIGITAL_VOLUME = 8'hc9;
  localparam logic [7:0] RST_GAIN_TRIM = 8'h80;

  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] MASK_INPUT_SETUP = 8'hfd;
  localparam logic [7:0] MASK_GAIN_TRIM = 8'hf0;

  localparam int POS_LINE_SELECT = 7;
  localparam int POS_SOURCE_LSB = 5;
  localparam int POS_COUPLING = 4;
  localparam int POS_IMPEDANCE_LSB = 2;
  localparam int POS_AUTO_GAIN = 0;
  localparam int POS_GAIN_LSB = 1;
  localparam int POS_POLARITY = 0;
  localparam int POS_TRIM_LSB = 4;

  localparam logic [1:0] SRC_ANALOG_DIFF = 2'h0;
  localparam logic [1:0] SRC_ANALOG_SINGLE = 2'h1;
  localparam logic [1:0] SRC_DIGITAL_PDM = 2'h2;
  localparam logic [1:0] IMP_2K5 = 2'h0;
  localparam logic [1:0] IMP_10K = 2'h1;
  localparam logic [1:0] IMP_20K = 2'h2;
  localparam logic [6:0] GAIN_CODE_MAX = 7'h54;
  localparam logic [7:0] VOLUME_MUTE = 8'h00;

  typedef struct packed {
    logic line_select;
    logic [1:0] source_select;
    logic coupling_select;
    logic [1:0] impedance_select;
    logic auto_gain_enable;
    logic source_is_analog;
    logic source_is_pdm;
  } ccr_front_end_s;

  typedef struct packed {
    logic [6:0] gain_code;
    logic gain_polarity;
    logic negative_gain_valid;
    logic [7:0] volume_code;
    logic volume_mute;
    logic [3:0] gain_trim_code;
  } ccr_gain_path_s;
endpackage

// ### hw/ccr_field_decode.sv
// Field decode from stored register bytes to front-end and gain path controls
`timescale 1ns/1ns
module ccr_field_decode (
  input wire logic [7:0] setup_byte,
  input wire logic [7:0] gain_byte,
  input wire logic [7:0] volume_byte,
  input wire logic [7:0] trim_byte,
  input wire logic agc_global_enable,
  output ccr_pkg::ccr_front_end_s front_end,
  output ccr_pkg::ccr_gain_path_s gain_path
);
  logic [1:0] src;
  logic [1:0] imp;

  assign src = setup_byte[ccr_pkg::POS_SOURCE_LSB +: 2];
  assign imp = setup_byte[ccr_pkg::POS_IMPEDANCE_LSB +: 2];

  always_comb begin
    front_end.line_select = setup_byte[ccr_pkg::POS_LINE_SELECT];
    front_end.source_select = src;
    front_end.source_is_analog = (src == ccr_pkg::SRC_ANALOG_DIFF) || (src == ccr_pkg::SRC_ANALOG_SINGLE);
    front_end.source_is_pdm = (src == ccr_pkg::SRC_DIGITAL_PDM);
    // Coupling and impedance only steer an analog source
    front_end.coupling_select = setup_byte[ccr_pkg::POS_COUPLING] & front_end.source_is_analog;
    front_end.impedance_select = front_end.source_is_analog ? imp : ccr_pkg::IMP_2K5;
    front_end.auto_gain_enable = setup_byte[ccr_pkg::POS_AUTO_GAIN] & agc_global_enable;
  end

  always_comb begin
    gain_path.gain_code = gain_byte[ccr_pkg::POS_GAIN_LSB +: 7];
    gain_path.gain_polarity = gain_byte[ccr_pkg::POS_POLARITY];
    gain_path.negative_gain_valid = gain_byte[ccr_pkg::POS_POLARITY] &&
      ((imp == ccr_pkg::IMP_10K) || (imp == ccr_pkg::IMP_20K));
    gain_path.volume_code = volume_byte;
    gain_path.volume_mute = (volume_byte == ccr_pkg::VOLUME_MUTE);
    gain_path.gain_trim_code = trim_byte[ccr_pkg::POS_TRIM_LSB +: 4];
  end
endmodule

// ### hw/ccr_channel_one_regs.sv
// Channel one configuration register bank behind the device control port
//
// Overview of operation
// - Bit 7 of input setup picks microphone (0) or line input (1).
// - Source bits 6-5: differential, single-ended, PDM; code 3 reserved.
// - Bit 4 picks AC or DC coupling, used only for analog sources.
// - Bits 3-2 pick 2.5k, 10k, 20k impedance; code 3 reserved.
// - Input setup bit 1 reserved, reads zero; host writes zero.
// - Bit 0 enables auto gain, qualified by bit 3 of the AGC control.
// - Gain code bits 7-1, 0.5 dB steps, 0 to 42 dB.
// - Bit 0 picks gain polarity; negative needs 10k or 20k impedance.
// - Volume code zero mutes the digital output.
// - Nonzero volume codes step 0.5 dB from -100 dB to +27 dB.
// - Volume resets to 0xc9, which is 0 dB.
// - Trim bits 7-4 step 0.1 dB from -0.8 to +0.7 dB.
// - Trim field resets to 1000, which is 0 dB.
// - Trim bits 3-0 reserved, read zero; host writes zero.
`timescale 1ns/1ns
module ccr_channel_one_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic agc_control_reg_bit3,
  output ccr_pkg::ccr_front_end_s front_end,
  output ccr_pkg::ccr_gain_path_s gain_path,
  output logic gain_code_reserved,
  output logic impedance_reserved,
  output logic source_reserved
);
  logic [7:0] input_setup_reg;
  logic [7:0] analog_gain_reg;
  logic [7:0] digital_volume_reg;
  logic [7:0] gain_trim_reg;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = addr_is(a, ccr_pkg::ADDR_INPUT_SETUP) || addr_is(a, ccr_pkg::ADDR_ANALOG_GAIN) ||
      addr_is(a, ccr_pkg::ADDR_DIGITAL_VOLUME) || addr_is(a, ccr_pkg::ADDR_GAIN_TRIM);
  endfunction

  // Reserved bit 1 is masked off on write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      input_setup_reg <= ccr_pkg::RST_INPUT_SETUP;
    end else if (reg_write && addr_is(reg_addr, ccr_pkg::ADDR_INPUT_SETUP)) begin
      input_setup_reg <= reg_wdata & ccr_pkg::MASK_INPUT_SETUP;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      analog_gain_reg <= ccr_pkg::RST_ANALOG_GAIN;
    end else if (reg_write && addr_is(reg_addr, ccr_pkg::ADDR_ANALOG_GAIN)) begin
      analog_gain_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      digital_volume_reg <= ccr_pkg::RST_DIGITAL_VOLUME;
    end else if (reg_write && addr_is(reg_addr, ccr_pkg::ADDR_DIGITAL_VOLUME)) begin
      digital_volume_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_trim_reg <= ccr_pkg::RST_GAIN_TRIM;
    end else if (reg_write && addr_is(reg_addr, ccr_pkg::ADDR_GAIN_TRIM)) begin
      gain_trim_reg <= reg_wdata & ccr_pkg::MASK_GAIN_TRIM;
    end
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (reg_read) begin
      reg_hit <= addr_mapped(reg_addr);
      case (reg_addr)
        ccr_pkg::ADDR_INPUT_SETUP: reg_rdata <= input_setup_reg;
        ccr_pkg::ADDR_ANALOG_GAIN: reg_rdata <= analog_gain_reg;
        ccr_pkg::ADDR_DIGITAL_VOLUME: reg_rdata <= digital_volume_reg;
        ccr_pkg::ADDR_GAIN_TRIM: reg_rdata <= gain_trim_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_hit <= 1'b0;
    end
  end

  ccr_field_decode u_decode (
    .setup_byte(input_setup_reg),
    .gain_byte(analog_gain_reg),
    .volume_byte(digital_volume_reg),
    .trim_byte(gain_trim_reg),
    .agc_global_enable(agc_control_reg_bit3),
    .front_end(front_end),
    .gain_path(gain_path)
  );

  // Flags for codes software should not have written
  assign gain_code_reserved = analog_gain_reg[ccr_pkg::POS_GAIN_LSB +: 7] > ccr_pkg::GAIN_CODE_MAX;
  assign impedance_reserved = &input_setup_reg[ccr_pkg::POS_IMPEDANCE_LSB +: 2];
  assign source_reserved = &input_setup_reg[ccr_pkg::POS_SOURCE_LSB +: 2];
endmodule

// ### testbench/ccr_channel_one_regs_properties.sv
// Port checker for the channel one register bank
`timescale 1ns/1ns
module ccr_regs_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic agc_control_reg_bit3,
  input wire ccr_pkg::ccr_front_end_s front_end,
  input wire ccr_pkg::ccr_gain_path_s gain_path
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic rd_map;
  assign rd_map = reg_read && reg_addr[7:2] == 6'h0f;
  read_hit_a: assert property (rd_map |=> reg_hit) else $error("no hit");
  unmapped_read_a: assert property (reg_read && !rd_map |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped answer");
  setup_reserved_a: assert property (reg_read && reg_addr == 8'h3c |=> !reg_rdata[1])
    else $error("setup bit 1 set");
  trim_reserved_a: assert property (reg_read && reg_addr == 8'h3f |=> reg_rdata[3:0] == 4'h0)
    else $error("trim low bits set");
  source_write_a: assert property (reg_write && reg_addr == 8'h3c |=>
    {front_end.line_select, front_end.source_select} == $past(reg_wdata) >> 5) else $error("setup lost");
  gain_write_a: assert property (reg_write && reg_addr == 8'h3d |=>
    {gain_path.gain_code, gain_path.gain_polarity} == $past(reg_wdata)) else $error("gain lost");
  volume_write_a: assert property (reg_write && reg_addr == 8'h3e |=>
    gain_path.volume_code == $past(reg_wdata)) else $error("volume lost");
  volume_mute_a: assert property (gain_path.volume_mute == (gain_path.volume_code == 8'h00))
    else $error("mute wrong");
  auto_gain_gate_a: assert property (!agc_control_reg_bit3 |-> !front_end.auto_gain_enable)
    else $error("auto gain ungated");
  cover property (reg_write && reg_addr == 8'h3e && reg_wdata == 8'h00);
  cover property (reg_hit);
  cover property (front_end.source_is_pdm);
endmodule

// ### testbench/ccr_host.sv
// Host model driving the control port strobes
`timescale 1ns/1ns
module ccr_host (
  input wire logic clock,
  output logic reg_write,
  output logic reg_read,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit
);
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Values pass unchecked; callers also write reserved bits; PDM pin routing lives outside
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic h);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
    h = reg_hit;
  endtask
endmodule

// ### testbench/ccr_channel_one_regs_tb_top.sv
// Testbench for the channel one register bank
`timescale 1ns/1ns
module ccr_channel_one_regs_tb_top;
  logic clock, rst, reg_write, reg_read, reg_hit, agc_control_reg_bit3, h;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic gain_code_reserved, impedance_reserved, source_reserved;
  ccr_pkg::ccr_front_end_s front_end;
  ccr_pkg::ccr_gain_path_s gain_path;
  int n_mismatch = 0;
  int checks = 0;
  ccr_channel_one_regs dut (
    .clock(clock),
    .rst(rst),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .agc_control_reg_bit3(agc_control_reg_bit3),
    .front_end(front_end),
    .gain_path(gain_path),
    .gain_code_reserved(gain_code_reserved),
    .impedance_reserved(impedance_reserved),
    .source_reserved(source_reserved)
  );
  ccr_host host (
    .clock(clock),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit)
  );
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d, h);
    cmp(d, exp);
    cmp({7'h00, h}, {7'h00, a[7:2] == 6'h0f});
  endtask
  initial begin
    rst = 1'b1;
    agc_control_reg_bit3 = 1'b0;
    repeat (16) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    rdc(8'h3c, 8'h00);
    rdc(8'h3d, 8'h00);
    rdc(8'h3e, 8'hc9);
    rdc(8'h3f, 8'h80);
    cmp({4'h0, gain_path.gain_trim_code}, 8'h08);
    for (int s = 0; s < 3; s++) begin
      host.wr(8'h3c, {1'b1, s[1:0], 5'h17});
      rdc(8'h3c, {1'b1, s[1:0], 5'h15});
      cmp({front_end.source_select, front_end.source_is_pdm}, {s[1:0], s == 2});
      cmp({front_end.coupling_select, front_end.impedance_select}, s == 2 ? 8'h00 : 8'h05);
      cmp({7'h00, front_end.auto_gain_enable}, 8'h00);
      cmp({6'h00, front_end.line_select, front_end.source_is_analog}, {6'h00, 1'b1, s != 2});
    end
    agc_control_reg_bit3 = 1'b1;
    host.wr(8'h3c, 8'h25);
    cmp({7'h00, front_end.auto_gain_enable}, 8'h01);
    cmp({4'h0, front_end.line_select, front_end.source_is_analog, source_reserved, impedance_reserved}, 8'h04);
    host.wr(8'h3d, 8'ha9);
    rdc(8'h3d, 8'ha9);
    cmp({gain_path.gain_code, gain_path.negative_gain_valid}, 8'ha9);
    cmp({6'h00, gain_path.gain_polarity, gain_code_reserved}, 8'h02);
    host.wr(8'h3e, 8'h00);
    cmp({7'h00, gain_path.volume_mute}, 8'h01);
    host.wr(8'h3e, 8'hff);
    cmp({gain_path.volume_code[6:0], gain_path.volume_mute}, 8'hfe);
    host.wr(8'h3f, 8'hff);
    rdc(8'h3f, 8'hf0);
    cmp({4'h0, gain_path.gain_trim_code}, 8'h0f);
    host.wr(8'h40, 8'h5a);
    rdc(8'h40, 8'h00);
    rdc(8'h3e, 8'hff);
    complete_run();
  end
  initial begin
    #6000;
    n_mismatch++;
    complete_run();
  end
endmodule
bind ccr_channel_one_regs ccr_regs_props chk (
  .clock(clock),
  .rst(rst),
  .reg_write(reg_write),
  .reg_read(reg_read),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .reg_hit(reg_hit),
  .agc_control_reg_bit3(agc_control_reg_bit3),
  .front_end(front_end),
  .gain_path(gain_path)
);
